// >>> src/iclu_pkg.sv
package iclu_pkg;

  // ---------------------------------------------------------------------
  // Datapath geometry.
  // ---------------------------------------------------------------------
  localparam int DATA_W     = 32;
  localparam int IMM_W      = 16;
  localparam int FIELD_W    = 4;
  localparam int NUM_FIELDS = 8;
  localparam int ADDR_W     = 8;

  // Bit positions inside one 4-bit condition field.
  localparam int FLD_LT = 3;
  localparam int FLD_GT = 2;
  localparam int FLD_EQ = 1;
  localparam int FLD_SO = 0;

  // The half word that fills the unused half of an immediate operand.
  localparam logic [15:0] IMM_ZERO_HALF = 16'h0000;

  // ---------------------------------------------------------------------
  // Control and status registers.
  // ---------------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL        = 8'h00;
  localparam logic [7:0]  REG_STAT        = 8'h04;
  localparam int          CTRL_EN_POS     = 0;
  localparam logic        CTRL_EN_RESET   = 1'b1;
  localparam int          STAT_CNT_POS    = 0;
  localparam int          STAT_FIELD_POS  = 16;
  localparam int          STAT_CRW_POS    = 19;
  localparam logic [15:0] OP_COUNT_RESET  = 16'h0000;
  localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;

  // ---------------------------------------------------------------------
  // Operation codes from the instruction sequencer.
  // ---------------------------------------------------------------------
  typedef enum logic [3:0] {
    signed_compare_reg_op   = 4'h0,
    signed_compare_imm_op   = 4'h1,
    unsigned_compare_reg_op = 4'h2,
    unsigned_compare_imm_op = 4'h3,
    and_imm_low_op          = 4'h4,
    and_imm_high_op         = 4'h5,
    or_imm_low_op           = 4'h6,
    or_imm_high_op          = 4'h7,
    xor_imm_low_op          = 4'h8,
    xor_imm_high_op         = 4'h9,
    and_reg_op              = 4'hA,
    or_reg_op               = 4'hB,
    xor_reg_op              = 4'hC,
    not_conj_op             = 4'hD,
    not_disj_op             = 4'hE
  } iclu_op_t;

endpackage

// >>> src/iclu_cmp_if.sv
`timescale 1ns/1ps
// Operands to the compare unit and the condition field it returns.
interface iclu_cmp_if;
  logic [31:0] lhs;
  logic [31:0] rhs;
  logic        signed_mode;
  logic        so_copy;
  logic [3:0]  field;

  modport req  (output lhs, rhs, signed_mode, so_copy, input field);
  modport unit (input lhs, rhs, signed_mode, so_copy, output field);
endinterface

// >>> src/iclu_cmp.sv
`timescale 1ns/1ps
module iclu_cmp
  import iclu_pkg::*;
(
  // Compare request and result.
  iclu_cmp_if.unit cmp
);

  // -----------------------------------------------------------------------
  // Three-way compare.
  // -----------------------------------------------------------------------

  // Exactly one of less, greater or equal is set; the fourth bit is a copy.
  always_comb begin
    logic lt;
    logic gt;
    lt = 1'b0;
    gt = 1'b0;
    if (cmp.signed_mode) begin
      lt = $signed(cmp.lhs) < $signed(cmp.rhs);
      gt = $signed(cmp.lhs) > $signed(cmp.rhs);
    end else begin
      lt = cmp.lhs < cmp.rhs;
      gt = cmp.lhs > cmp.rhs;
    end
    cmp.field = {lt, gt, (cmp.lhs == cmp.rhs), cmp.so_copy};
  end

endmodule // iclu_cmp

// >>> src/iclu_top.sv
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// Summary of operation
// - Signed compares treat both 32-bit operands as two's complement.
// - Unsigned compares treat both 32-bit operands as magnitudes.
// - Signed immediate compare sign-extends the 16-bit immediate first.
// - Unsigned immediate compare zero-extends the 16-bit immediate first.
// - A compare writes only its selected field; others stay unchanged.
// - The operand-width field is ignored; compares are always 32-bit.
// - The destination selector reaches any of fields zero to seven.
// - Recording logicals and both AND-immediate forms update field zero.
// - Field zero then holds the signed compare of the result with zero.
// - Other logical operations leave every condition field untouched.
// - Logical operations never touch the exception register flags.
// - AND immediate low/high use the immediate in that half, zeros else.
// - OR immediate low uses the zero-extended immediate.
// - OR immediate high uses the immediate in the upper half.
// - XOR immediate low/high place the immediate in that half.
// - Register AND, OR and XOR combine the two sources bit by bit.
// - Not-conjunction and not-disjunction invert the AND or OR result.
// - Each register logical has a recording variant via the record bit.
module iclu_top
  import iclu_pkg::*;
(
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        rst,
  // Operation from the instruction sequencer.
  input  wire logic        op_valid,
  input  wire iclu_op_t    op_code,
  input  wire logic [2:0]  cond_field_dest,
  input  wire logic        record_bit,
  input  wire logic        width_sel,
  input  wire logic [31:0] src_a_gpr,
  input  wire logic [31:0] src_s_gpr,
  input  wire logic [31:0] src_b_gpr,
  input  wire logic [15:0] imm16,
  // Current architectural state.
  input  wire logic [31:0] cr_in,
  input  wire logic        summary_overflow,
  // Results to the register file and condition register.
  output logic             res_valid,
  output logic             gpr_wr,
  output logic [31:0]      res_data,
  output logic             cr_wr,
  output logic [7:0]       cr_mask,
  output logic [31:0]      cr_out,
  output logic             exc_flags_wr,
  // Register port.
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata
);

  // -----------------------------------------------------------------------
  // Helper functions.
  // -----------------------------------------------------------------------

  // Lowest bit of a field; field zero sits in the top nibble.
  function automatic logic [4:0] field_lsb(input logic [2:0] idx);
    return {(3'd7 - idx), 2'b00};
  endfunction

  // Reads one 4-bit field out of a condition register word.
  function automatic logic [3:0] get_field(input logic [31:0] cr,
                                           input logic [2:0]  idx);
    return cr[field_lsb(idx) +: FIELD_W];
  endfunction

  // Reads one flag bit of one field of a condition register word.
  function automatic logic field_bit(input logic [31:0] cr,
                                     input logic [2:0]  idx, input int pos);
    return cr[field_lsb(idx) + pos];
  endfunction

  // Replaces one field and keeps all others.
  function automatic logic [31:0] put_field(input logic [31:0] cr,
                                            input logic [2:0]  idx,
                                            input logic [3:0]  f);
    logic [31:0] r;
    r = cr;
    r[field_lsb(idx) +: FIELD_W] = f;
    return r;
  endfunction

  // True for the four compare operations.
  function automatic logic is_compare(input iclu_op_t op);
    return (op == signed_compare_reg_op) || (op == signed_compare_imm_op) ||
           (op == unsigned_compare_reg_op) ||
           (op == unsigned_compare_imm_op);
  endfunction

  // True when a logical operation must update field zero.
  function automatic logic records(input iclu_op_t op, input logic rec);
    return rec || (op == and_imm_low_op) || (op == and_imm_high_op);
  endfunction

  // Result of every logical operation.
  function automatic logic [31:0] logic_res(input iclu_op_t    op,
                                            input logic [31:0] s,
                                            input logic [31:0] b,
                                            input logic [15:0] imm);
    logic [31:0] lo;
    logic [31:0] hi;
    lo = {IMM_ZERO_HALF, imm};
    hi = {imm, IMM_ZERO_HALF};
    case (op)
      and_imm_low_op:  logic_res = s & lo;
      and_imm_high_op: logic_res = s & hi;
      or_imm_low_op:   logic_res = s | lo;
      or_imm_high_op:  logic_res = s | hi;
      xor_imm_low_op:  logic_res = s ^ lo;
      xor_imm_high_op: logic_res = s ^ hi;
      and_reg_op:      logic_res = s & b;
      or_reg_op:       logic_res = s | b;
      xor_reg_op:      logic_res = s ^ b;
      not_conj_op:     logic_res = ~(s & b);
      not_disj_op:     logic_res = ~(s | b);
      default:         logic_res = WORD_ZERO;
    endcase
  endfunction

  // -----------------------------------------------------------------------
  // State.
  // -----------------------------------------------------------------------

  typedef struct packed {
    logic        ctrl_en;
    logic [31:0] rdata;
    logic        res_valid;
    logic        gpr_wr;
    logic [31:0] res_data;
    logic        cr_wr;
    logic [7:0]  cr_mask;
    logic [31:0] cr_out;
    logic        exc_flags_wr;
    logic [15:0] op_count;
    logic [2:0]  last_field;
    logic        last_crw;
  } iclu_state_t;

  iclu_state_t state;
  iclu_state_t next_state;
  iclu_cmp_if  cmp_bus ();

  logic        accept;
  logic [31:0] lres;

  // An operation is taken only while the unit is enabled.
  assign accept = op_valid && state.ctrl_en;
  assign lres   = logic_res(op_code, src_s_gpr, src_b_gpr, imm16);

  // -----------------------------------------------------------------------
  // Compare operand selection.
  // -----------------------------------------------------------------------

  // Compares use their operands; logicals compare the result with zero.
  always_comb begin
    cmp_bus.so_copy = summary_overflow;
    case (op_code)
      signed_compare_reg_op: begin
        cmp_bus.lhs         = src_a_gpr;
        cmp_bus.rhs         = src_b_gpr;
        cmp_bus.signed_mode = 1'b1;
      end
      signed_compare_imm_op: begin
        cmp_bus.lhs         = src_a_gpr;
        cmp_bus.rhs         = {{IMM_W{imm16[15]}}, imm16};
        cmp_bus.signed_mode = 1'b1;
      end
      unsigned_compare_reg_op: begin
        cmp_bus.lhs         = src_a_gpr;
        cmp_bus.rhs         = src_b_gpr;
        cmp_bus.signed_mode = 1'b0;
      end
      unsigned_compare_imm_op: begin
        cmp_bus.lhs         = src_a_gpr;
        cmp_bus.rhs         = {IMM_ZERO_HALF, imm16};
        cmp_bus.signed_mode = 1'b0;
      end
      default: begin
        cmp_bus.lhs         = lres;
        cmp_bus.rhs         = WORD_ZERO;
        cmp_bus.signed_mode = 1'b1;
      end
    endcase
  end

  // The shared three-way compare unit.
  iclu_cmp u_cmp (
    .cmp (cmp_bus.unit)
  );

  // -----------------------------------------------------------------------
  // Next-state logic.
  // -----------------------------------------------------------------------

  // Width select is never read: every compare is a 32-bit compare.
  always_comb begin
    next_state           = state;
    next_state.res_valid = 1'b0;
    next_state.gpr_wr    = 1'b0;
    next_state.cr_wr     = 1'b0;
    next_state.cr_mask   = 8'h00;
    next_state.exc_flags_wr = 1'b0;
    next_state.rdata     = WORD_ZERO;
    if (accept) begin
      next_state.res_valid = 1'b1;
      next_state.op_count  = state.op_count + 16'h0001;
      if (is_compare(op_code)) begin
        // Only the addressed field changes.
        next_state.cr_wr      = 1'b1;
        next_state.cr_mask    = 8'h01 << cond_field_dest;
        next_state.cr_out     = put_field(cr_in, cond_field_dest,
                                          cmp_bus.field);
        next_state.last_field = cond_field_dest;
        next_state.last_crw   = 1'b1;
      end else begin
        next_state.gpr_wr   = 1'b1;
        next_state.res_data = lres;
        next_state.last_crw = 1'b0;
        if (records(op_code, record_bit)) begin
          next_state.cr_wr      = 1'b1;
          next_state.cr_mask    = 8'h01;
          next_state.cr_out     = put_field(cr_in, 3'd0, cmp_bus.field);
          next_state.last_field = 3'd0;
          next_state.last_crw   = 1'b1;
        end
      end
    end
    // Register writes and reads.
    if (reg_wr && (reg_addr == REG_CTRL)) begin
      next_state.ctrl_en = reg_wdata[CTRL_EN_POS];
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: next_state.rdata[CTRL_EN_POS] = state.ctrl_en;
        REG_STAT: begin
          next_state.rdata[STAT_CNT_POS +: 16]  = state.op_count;
          next_state.rdata[STAT_FIELD_POS +: 3] = state.last_field;
          next_state.rdata[STAT_CRW_POS]        = state.last_crw;
        end
        default:  next_state.rdata = WORD_ZERO;
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // State register.
  // -----------------------------------------------------------------------

  // All state is registered here; reset loads constants only.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state            <= '0;
      state.ctrl_en    <= CTRL_EN_RESET;
      state.op_count   <= OP_COUNT_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from the state register.
  assign res_valid = state.res_valid;
  assign gpr_wr    = state.gpr_wr;
  assign res_data  = state.res_data;
  assign cr_wr     = state.cr_wr;
  assign cr_mask   = state.cr_mask;
  assign cr_out    = state.cr_out;
  assign exc_flags_wr = state.exc_flags_wr;
  assign reg_rdata = state.rdata;

  // -----------------------------------------------------------------------
  // Assertions.
  // -----------------------------------------------------------------------

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic [31:0] mask32;

  // Expands the field mask to a bit mask of the condition word.
  always_comb begin
    mask32 = WORD_ZERO;
    for (int i = 0; i < NUM_FIELDS; i++) begin
      if (cr_mask[i]) begin
        mask32[field_lsb(3'(i)) +: FIELD_W] = 4'hF;
      end
    end
  end

  a_signed_reg_cmp: assert property (
    accept && op_code == signed_compare_reg_op |=> cr_wr &&
    field_bit(cr_out, $past(cond_field_dest), FLD_LT) ==
      ($signed($past(src_a_gpr)) < $signed($past(src_b_gpr))))
    else $error("signed compare gave wrong less-than bit");

  a_unsigned_cmp: assert property (
    accept && op_code == unsigned_compare_reg_op |=> cr_wr &&
    field_bit(cr_out, $past(cond_field_dest), FLD_GT) ==
      ($past(src_a_gpr) > $past(src_b_gpr)))
    else $error("unsigned compare gave wrong greater-than bit");

  a_signed_imm_ext: assert property (
    accept && op_code == signed_compare_imm_op |=>
    field_bit(cr_out, $past(cond_field_dest), FLD_LT) ==
      ($signed($past(src_a_gpr)) <
       $signed({{16{$past(imm16[15])}}, $past(imm16)})))
    else $error("signed immediate not sign-extended");

  a_unsigned_imm_ext: assert property (
    accept && op_code == unsigned_compare_imm_op |=>
    field_bit(cr_out, $past(cond_field_dest), FLD_EQ) ==
      ($past(src_a_gpr) == {16'h0000, $past(imm16)}))
    else $error("unsigned immediate not zero-extended");

  a_other_fields: assert property (
    cr_wr |-> (cr_out & ~mask32) == ($past(cr_in) & ~mask32))
    else $error("unselected condition field changed");

  a_field_select: assert property (
    accept && is_compare(op_code) |=>
    cr_mask == (8'h01 << $past(cond_field_dest)) && !gpr_wr)
    else $error("compare wrote the wrong field");

  a_record_zero: assert property (
    accept && !is_compare(op_code) && records(op_code, record_bit) |=>
    cr_wr && cr_mask == 8'h01 && gpr_wr &&
    field_bit(cr_out, 3'd0, FLD_LT) == res_data[31] &&
    field_bit(cr_out, 3'd0, FLD_EQ) == (res_data == 32'h0000_0000))
    else $error("field zero does not characterise the result");

  a_no_record: assert property (
    accept && !is_compare(op_code) && !records(op_code, record_bit) |=>
    !cr_wr ##1 !cr_wr || $past(accept))
    else $error("non-recording logical touched the condition register");

  a_exc_untouched: assert property (
    $past(accept) && !is_compare($past(op_code)) |-> !exc_flags_wr)
    else $error("logical operation wrote the exception flags");

  a_imm_result: assert property (
    accept && op_code == or_imm_high_op |=>
    res_data == ($past(src_s_gpr) | {$past(imm16), 16'h0000}))
    else $error("immediate-high OR result wrong");

  a_reg_result: assert property (
    accept && op_code == not_disj_op |=>
    res_data == ~($past(src_s_gpr) | $past(src_b_gpr)))
    else $error("inverted OR result wrong");

  a_field_onehot: assert property (
    cr_wr |-> $onehot(get_field(cr_out, state.last_field) >> FLD_EQ) &&
    field_bit(cr_out, state.last_field, FLD_SO) == $past(summary_overflow))
    else $error("written field is not one-hot with copied SO");

  c_cmp_field7: cover property (
    accept && is_compare(op_code) && cond_field_dest == 3'd7);
  c_andi_record: cover property (
    accept && op_code == and_imm_high_op ##1 cr_wr);
  c_nop_op: cover property (
    accept && op_code == or_imm_low_op && imm16 == 16'h0000);
  c_back_to_back: cover property (accept ##1 accept ##1 accept);

endmodule // iclu_top

// >>> dv/iclu_seq_model.sv
`timescale 1ns/1ps
// --------------------------------------------------------------------------
// Sequencer side model: holds the condition register and feeds it back.
// --------------------------------------------------------------------------
module iclu_seq_model
  import iclu_pkg::*;
#(
  parameter logic [31:0] CR_INIT = 32'h1357_9BDF
)
(
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        rst,
  // Condition register write from the block.
  input  wire logic        cr_wr,
  input  wire logic [31:0] cr_out,
  // Latest condition register value back to the block.
  output logic [31:0]      cr_in
);
  logic [31:0] cr_q;

  // The condition register takes every full word the block writes.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cr_q <= CR_INIT;
    end else if (cr_wr) begin
      cr_q <= cr_out;
    end
  end

  // A write in flight is bypassed so back-to-back operations see it.
  assign cr_in = cr_wr ? cr_out : cr_q;
endmodule // iclu_seq_model

// >>> dv/tb.sv
`timescale 1ns/1ps
// --------------------------------------------------------------------------
// Self-checking bench for the compare and logical unit.
// --------------------------------------------------------------------------
module tb
  import iclu_pkg::*;
;
  localparam logic [31:0] CR_INIT = 32'h1357_9BDF;

  typedef struct {
    iclu_op_t op; logic [2:0] dest; logic rec; logic ws;
    logic [31:0] a; logic [31:0] s; logic [31:0] b; logic [15:0] imm;
    logic gw; logic [31:0] res; logic [7:0] mask; logic [3:0] fld;
  } iclu_row_t;

  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        op_valid = 1'b0;
  iclu_op_t    op_code = or_imm_low_op;
  logic [2:0]  cond_field_dest = 3'h0;
  logic        record_bit = 1'b0;
  logic        width_sel = 1'b0;
  logic [31:0] src_a_gpr = 32'h0;
  logic [31:0] src_s_gpr = 32'h0;
  logic [31:0] src_b_gpr = 32'h0;
  logic [15:0] imm16 = 16'h0;
  logic        summary_overflow = 1'b0;
  logic [7:0]  reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] cr_in, res_data, cr_out, reg_rdata, exp_cr, rd;
  logic        res_valid, gpr_wr, cr_wr, exc_flags_wr;
  logic [7:0]  cr_mask;
  int          n_mismatch = 0;
  int          checks = 0;
  int          n_ops = 0;
  int          cyc = 0;

  iclu_row_t rows [20] = '{
    '{signed_compare_reg_op, 3'h3, 1'h0, 1'h0, 32'hFFFFFFFF, 32'h0,
      32'h1, 16'h0, 1'h0, 32'h0, 8'h08, 4'h8},
    '{unsigned_compare_reg_op, 3'h5, 1'h0, 1'h0, 32'hFFFFFFFF, 32'h0,
      32'h1, 16'h0, 1'h0, 32'h0, 8'h20, 4'h4},
    '{signed_compare_reg_op, 3'h0, 1'h0, 1'h1, 32'h7FFFFFFF, 32'h0,
      32'h80000000, 16'h0, 1'h0, 32'h0, 8'h01, 4'h4},
    '{signed_compare_imm_op, 3'h7, 1'h0, 1'h0, 32'hFFFF8000, 32'h0,
      32'h0, 16'h8000, 1'h0, 32'h0, 8'h80, 4'h2},
    '{unsigned_compare_imm_op, 3'h1, 1'h0, 1'h0, 32'h00008000, 32'h0,
      32'h0, 16'h8000, 1'h0, 32'h0, 8'h02, 4'h2},
    '{unsigned_compare_imm_op, 3'h2, 1'h0, 1'h1, 32'hFFFF8000, 32'h0,
      32'h0, 16'h8000, 1'h0, 32'h0, 8'h04, 4'h4},
    '{unsigned_compare_reg_op, 3'h6, 1'h0, 1'h0, 32'h1, 32'h0,
      32'h80000000, 16'h0, 1'h0, 32'h0, 8'h40, 4'h8},
    '{and_imm_low_op, 3'h4, 1'h0, 1'h0, 32'h0, 32'hFFFF1234,
      32'h0, 16'hF0F0, 1'h1, 32'h00001030, 8'h01, 4'h4},
    '{and_imm_high_op, 3'h5, 1'h0, 1'h0, 32'h0, 32'h8765FFFF,
      32'h0, 16'hFF00, 1'h1, 32'h87000000, 8'h01, 4'h8},
    '{or_imm_low_op, 3'h3, 1'h0, 1'h0, 32'h0, 32'h12000000,
      32'h0, 16'h00AB, 1'h1, 32'h120000AB, 8'h00, 4'h0},
    '{or_imm_high_op, 3'h0, 1'h0, 1'h0, 32'h0, 32'h000000FF,
      32'h0, 16'h8000, 1'h1, 32'h800000FF, 8'h00, 4'h0},
    '{xor_imm_low_op, 3'h0, 1'h0, 1'h0, 32'h0, 32'hFFFFFFFF,
      32'h0, 16'h00FF, 1'h1, 32'hFFFFFF00, 8'h00, 4'h0},
    '{xor_imm_high_op, 3'h0, 1'h0, 1'h0, 32'h0, 32'hFFFFFFFF,
      32'h0, 16'h00FF, 1'h1, 32'hFF00FFFF, 8'h00, 4'h0},
    '{and_reg_op, 3'h6, 1'h1, 1'h0, 32'h0, 32'hF0F0F0F0,
      32'hFF00FF00, 16'h0, 1'h1, 32'hF000F000, 8'h01, 4'h8},
    '{or_reg_op, 3'h0, 1'h0, 1'h0, 32'h0, 32'h0F0F0000,
      32'h000000F0, 16'h0, 1'h1, 32'h0F0F00F0, 8'h00, 4'h0},
    '{xor_reg_op, 3'h0, 1'h1, 1'h0, 32'h0, 32'hA5A5A5A5,
      32'hA5A5A5A5, 16'h0, 1'h1, 32'h00000000, 8'h01, 4'h2},
    '{not_conj_op, 3'h0, 1'h1, 1'h0, 32'h0, 32'hFFFF0000,
      32'hFFFFFFFF, 16'h0, 1'h1, 32'h0000FFFF, 8'h01, 4'h4},
    '{not_disj_op, 3'h0, 1'h0, 1'h0, 32'h0, 32'h0,
      32'h0, 16'h0, 1'h1, 32'hFFFFFFFF, 8'h00, 4'h0},
    '{not_disj_op, 3'h0, 1'h1, 1'h0, 32'h0, 32'h80000000,
      32'h1, 16'h0, 1'h1, 32'h7FFFFFFE, 8'h01, 4'h4},
    '{or_imm_low_op, 3'h0, 1'h0, 1'h0, 32'h0, 32'h0,
      32'h0, 16'h0, 1'h1, 32'h0, 8'h00, 4'h0}
  };

  iclu_top dut (.mclk(mclk), .rst(rst), .op_valid(op_valid),
    .op_code(op_code), .cond_field_dest(cond_field_dest),
    .record_bit(record_bit), .width_sel(width_sel), .src_a_gpr(src_a_gpr),
    .src_s_gpr(src_s_gpr), .src_b_gpr(src_b_gpr), .imm16(imm16),
    .cr_in(cr_in), .summary_overflow(summary_overflow),
    .res_valid(res_valid), .gpr_wr(gpr_wr), .res_data(res_data),
    .cr_wr(cr_wr), .cr_mask(cr_mask), .cr_out(cr_out),
    .exc_flags_wr(exc_flags_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  iclu_seq_model #(.CR_INIT(CR_INIT)) seq (.mclk(mclk), .rst(rst),
    .cr_wr(cr_wr), .cr_out(cr_out), .cr_in(cr_in));

  // The clock toggles every half period of 10 ns.
  always #10 mclk = ~mclk;

  // A hung run is cut short after a generous cycle ceiling.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // --------------------------------------------------------------------------
  // Compare, drive and report tasks.
  // --------------------------------------------------------------------------
  task automatic chk_word(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_flag(input string nm, input logic e, input logic g);
    chk_word(nm, {31'h0, e}, {31'h0, g});
  endtask

  task automatic drive(input iclu_row_t r);
    op_valid <= 1'b1;
    op_code <= r.op;
    cond_field_dest <= r.dest;
    record_bit <= r.rec;
    width_sel <= r.ws;
    src_a_gpr <= r.a;
    src_s_gpr <= r.s;
    src_b_gpr <= r.b;
    imm16 <= r.imm;
  endtask

  task automatic check_row(input iclu_row_t r);
    logic [2:0]  idx;
    logic [31:0] ecr;
    idx = (r.op < and_imm_low_op) ? r.dest : 3'h0;
    ecr = exp_cr;
    if (r.mask != 8'h00) begin
      ecr[31 - 4 * idx -: 4] = r.fld;
    end
    chk_flag("res_valid", 1'b1, res_valid);
    chk_flag("gpr_wr", r.gw, gpr_wr);
    if (r.gw) begin
      chk_word("res_data", r.res, res_data);
    end
    chk_flag("cr_wr", r.mask != 8'h00, cr_wr);
    chk_word("cr_mask", {24'h0, r.mask}, {24'h0, cr_mask});
    if (r.mask != 8'h00) begin
      chk_word("cr_out", ecr, cr_out);
    end
    chk_flag("exc_flags_wr", 1'b0, exc_flags_wr);
    exp_cr = ecr;
    n_ops++;
  endtask

  task automatic run_row(input iclu_row_t r);
    @(posedge mclk) drive(r);
    @(posedge mclk) op_valid <= 1'b0;
    #1 check_row(r);
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk) reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk) reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk) reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic print_verdict();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Main sequence: reset, table rows, then the awkward cases.
  // --------------------------------------------------------------------------
  initial begin
    exp_cr = CR_INIT;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    #1 chk_flag("res_valid", 1'b0, res_valid);
    chk_word("cr_out", 32'h0, cr_out);
    reg_read(REG_CTRL, rd);
    chk_word("ctrl", 32'h1, rd);
    $display("test reset done");
    foreach (rows[i]) begin
      run_row(rows[i]);
    end
    $display("test table done");
    // The copied overflow bit lands in the written field.
    @(posedge mclk) summary_overflow <= 1'b1;
    run_row('{signed_compare_reg_op, 3'h6, 1'h0, 1'h0, 32'h5, 32'h0,
              32'h5, 16'h0, 1'h0, 32'h0, 8'h40, 4'h3});
    @(posedge mclk) summary_overflow <= 1'b0;
    $display("test overflow copy done");
    // Two compares in consecutive cycles keep each other's fields.
    @(posedge mclk) drive('{signed_compare_imm_op, 3'h1, 1'h0, 1'h0,
      32'h0, 32'h0, 32'h0, 16'hFFFF, 1'h0, 32'h0, 8'h02, 4'h4});
    @(posedge mclk) drive('{unsigned_compare_imm_op, 3'h2, 1'h0, 1'h0,
      32'h0, 32'h0, 32'h0, 16'hFFFF, 1'h0, 32'h0, 8'h04, 4'h8});
    #1 check_row('{signed_compare_imm_op, 3'h1, 1'h0, 1'h0, 32'h0,
      32'h0, 32'h0, 16'hFFFF, 1'h0, 32'h0, 8'h02, 4'h4});
    @(posedge mclk) op_valid <= 1'b0;
    #1 check_row('{unsigned_compare_imm_op, 3'h2, 1'h0, 1'h0, 32'h0,
      32'h0, 32'h0, 16'hFFFF, 1'h0, 32'h0, 8'h04, 4'h8});
    $display("test back to back done");
    reg_read(REG_STAT, rd);
    chk_word("stat", {12'h0, 1'b1, 3'h2, n_ops[15:0]}, rd);
    reg_read(8'h08, rd);
    chk_word("unmapped", 32'h0, rd);
    // Read data stand for one cycle only and then drop back to zero.
    @(posedge mclk) #1 chk_word("rdata_idle", 32'h0, reg_rdata);
    reg_write(8'h08, 32'h0);
    reg_write(REG_CTRL, 32'h0);
    @(posedge mclk) drive(rows[0]);
    @(posedge mclk) op_valid <= 1'b0;
    #1 chk_flag("res_valid", 1'b0, res_valid);
    @(posedge mclk) #1 chk_flag("res_valid", 1'b0, res_valid);
    reg_read(REG_STAT, rd);
    chk_word("stat", {12'h0, 1'b1, 3'h2, n_ops[15:0]}, rd);
    reg_write(REG_CTRL, 32'h1);
    run_row(rows[13]);
    $display("test registers done");
    print_verdict();
  end
endmodule // tb
